// [src/asm_regs.svh]
// Summary of operation
// - Loading the accumulator pushes its previous value onto stack level one.
// - Binary subtract: accumulator minus stack level one, difference to accumulator.
// - Binary multiply: 16-bit stack level one times 16-bit accumulator, 32-bit product.
// - After binary multiply, drop level one and move the stack up one level.
// - Binary divide: 32-bit accumulator by 16-bit level one, quotient to accumulator.
// - After binary divide, the remainder goes into stack level one.
// - Zero flag set whenever an instruction leaves the accumulator at zero.
// - Negative flag set when multiply, divide, real or shift result is negative.
// - Operand range flag set when a divide or real operand is out of range.
// - Each instruction overwrites only the flags it uses with its own result; real operations also clear the sign error flag.
// - Real operations read and write IEEE single values in the accumulator.
// - Sine, cosine and tangent take the accumulator value as radians.
// - Inverse sine, cosine and tangent replace the accumulator value.
// - Square root replaces the value and accepts any positive real.
// - Invalid real flag set for a malformed float during a real operation.
// - Non-real flag set when a real operation meets a non-real value.
// - Sign error flag set when signed subtraction gives a wrong sign bit.
// - Bit count leaves the number of one bits in the accumulator.
// - Left shift by 1-32 positions from a constant or a memory word.
// - Left shift fills low bits with zeros and discards bits shifted out.
`ifndef ASM_REGS_SVH
`define ASM_REGS_SVH
`define ASM_A_DATA 8'h00
`define ASM_A_CMD 8'h04
`define ASM_A_SHC 8'h08
`define ASM_A_STK 8'h0c
`define ASM_A_FLG 8'h10
`define ASM_OP_SUB 5'h01
`define ASM_OP_MUL 5'h02
`define ASM_OP_DIV 5'h03
`define ASM_OP_SIN 5'h04
`define ASM_OP_COS 5'h05
`define ASM_OP_TAN 5'h06
`define ASM_OP_ASIN 5'h07
`define ASM_OP_ACOS 5'h08
`define ASM_OP_ATAN 5'h09
`define ASM_OP_SQRT 5'h0a
`define ASM_OP_SUM 5'h0b
`define ASM_OP_SHLK 5'h0c
`define ASM_OP_SHLM 5'h0d
`define ASM_OP_HI 4
`define ASM_K_HI 13
`define ASM_K_LO 8
`define ASM_BUSY_BIT 31
`define ASM_F_RANGE 0
`define ASM_F_ZERO 1
`define ASM_F_NEG 2
`define ASM_F_INV 3
`define ASM_F_SERR 4
`define ASM_F_NREAL 5
`define ASM_NFLG 6
`define ASM_FB 28
`define ASM_BIAS 127
`define ASM_FOFS 122
`define ASM_FEXP 99
`define ASM_FOVF 8
`define ASM_ATAN_E 129
`define ASM_EMAX 8'hff
`define ASM_ONE 34'h010000000
`define ASM_PI 34'h03243f6a8
`define ASM_HPI 34'h01921fb54
`define ASM_KGAIN 34'h009b74eda
`define ASM_NIT 7'h1c
`define ASM_NDIV 7'h40
`define ASM_SQTOP 7'h1f
`endif

// [src/asm_pkg.sv]
`include "asm_regs.svh"
package asm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ROT,
    ST_VEC,
    ST_DIV,
    ST_SQRT
  } asm_state_t;
endpackage

// [src/asm_math_unit.sv]
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`include "asm_regs.svh"
module asm_math_unit #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic busy
);
  import asm_pkg::*;

  function automatic logic [34:0] f2fix(input logic [31:0] f,
                                        input int dn);
    int sh;
    logic [63:0] m;
    logic [33:0] v;
    sh = int'(f[30:23]) - `ASM_FOFS - dn;
    m = {40'h0, 1'b1, f[22:0]};
    if (f[30:23] == 8'h00)
      v = '0;
    else if (sh >= 0)
      v = m[33:0] << sh;
    else
      v = m[33:0] >> (-sh);
    if (f[31])
      v = -v;
    return {(sh >= `ASM_FOVF) && (f[30:23] != 8'h00), v};
  endfunction

  function automatic logic [31:0] fix2f(input logic [33:0] v);
    logic [33:0] a;
    logic [33:0] n;
    int p;
    a = v[33] ? -v : v;
    p = 0;
    for (int i = 0; i < 34; i++) begin
      if (a[i])
        p = i;
    end
    n = a << (33 - p);
    if (a == '0)
      return '0;
    return {v[33], 8'(p + `ASM_FEXP), n[32:10]};
  endfunction

  // Radian arctangent table; beyond it atan(2^-i) equals 2^-i
  function automatic logic [33:0] atan_t(input logic [6:0] i);
    case (i)
      7'h00: return 34'h00c90fdaa;
      7'h01: return 34'h0076b19c1;
      7'h02: return 34'h003eb6ebf;
      7'h03: return 34'h001fd5ba9;
      7'h04: return 34'h000ffaadd;
      7'h05: return 34'h0007ff556;
      7'h06: return 34'h0003ffeaa;
      7'h07: return 34'h0001fffd5;
      7'h08: return 34'h0000ffffa;
      7'h09: return 34'h00007ffff;
      default: return `ASM_ONE >> i;
    endcase
  endfunction

  function automatic logic zf(input logic [31:0] v, input logic r);
    return r ? (v[30:0] == '0) : (v == '0);
  endfunction

  function automatic logic [5:0] popcnt(input logic [31:0] v);
    logic [5:0] c;
    c = '0;
    for (int i = 0; i < 32; i++)
      c = c + {5'h0, v[i]};
    return c;
  endfunction

  logic pend_reg, pend_next, pwr_reg, pwr_next;
  logic [7:0] paddr_reg, paddr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic hready_reg, hready_next, hresp_reg;
  logic accept, stall, bfin, wr_data, wr_cmd, wr_shc;

  asm_state_t st_reg, st_next;
  logic [31:0] acc_reg, acc_next, shc_reg, shc_next;
  logic [31:0] stk_reg [STACK_DEPTH];
  logic [31:0] stk_next [STACK_DEPTH];
  logic [`ASM_NFLG-1:0] flg_reg, flg_next;
  logic [4:0] op_reg, op_next;
  logic [6:0] cnt_reg, cnt_next;
  logic signed [33:0] x_reg, x_next, y_reg, y_next, z_reg, z_next;
  logic neg_reg, neg_next, busy_reg;
  logic [7:0] ex_reg, ex_next;
  logic [63:0] dvd_reg, dvd_next, rad_reg, rad_next;
  logic [31:0] rem_reg, rem_next, dsr_reg, dsr_next;
  logic [31:0] root_reg, root_next;

  logic [34:0] fx, fa;
  logic signed [33:0] fxv, absx, xs, ys, at, sv, cv, abss, absc, zz, v;
  logic signed [67:0] sq;
  logic [7:0] e8;
  logic isinv, nreal, dir, dge, tok, do_push, do_pop, fin, hold, rng;
  logic s0_wr;
  logic [32:0] dr;
  logic [31:0] trial, root_n, res, diff, s0_val;
  logic [63:0] tsq;
  logic [5:0] kc;
  int dn;

  // Bus slave: one wait state so that read data comes from a flop
  always_comb begin
    accept = hsel && htrans[1] && hready;
    stall = pend_reg && pwr_reg && (st_reg != ST_IDLE) &&
            (paddr_reg == `ASM_A_DATA || paddr_reg == `ASM_A_CMD);
    bfin = pend_reg && !stall;
    wr_data = bfin && pwr_reg && paddr_reg == `ASM_A_DATA;
    wr_cmd = bfin && pwr_reg && paddr_reg == `ASM_A_CMD;
    wr_shc = bfin && pwr_reg && paddr_reg == `ASM_A_SHC;
    pend_next = pend_reg;
    pwr_next = pwr_reg;
    paddr_next = paddr_reg;
    hready_next = hready_reg;
    hrdata_next = hrdata_reg;
    if (accept) begin
      pend_next = 1'b1;
      pwr_next = hwrite;
      paddr_next = haddr[7:0];
      hready_next = 1'b0;
    end else if (bfin) begin
      pend_next = 1'b0;
      hready_next = 1'b1;
      if (!pwr_reg) begin
        hrdata_next = '0;
        case (paddr_reg)
          `ASM_A_DATA: hrdata_next = acc_reg;
          `ASM_A_CMD: begin
            hrdata_next[`ASM_OP_HI:0] = op_reg;
            hrdata_next[`ASM_BUSY_BIT] = st_reg != ST_IDLE;
          end
          `ASM_A_SHC: hrdata_next = shc_reg;
          `ASM_A_STK: hrdata_next = stk_reg[0];
          `ASM_A_FLG: hrdata_next[`ASM_NFLG-1:0] = flg_reg;
          default: hrdata_next = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pend_reg <= 1'b0;
      pwr_reg <= 1'b0;
      paddr_reg <= '0;
      hrdata_reg <= '0;
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      pwr_reg <= pwr_next;
      paddr_reg <= paddr_next;
      hrdata_reg <= hrdata_next;
      hready_reg <= hready_next;
      hresp_reg <= 1'b0;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp = hresp_reg;
  assign busy = busy_reg;

  always_comb begin
    acc_next = acc_reg;
    stk_next = stk_reg;
    flg_next = flg_reg;
    st_next = st_reg;
    op_next = op_reg;
    cnt_next = cnt_reg;
    x_next = x_reg;
    y_next = y_reg;
    z_next = z_reg;
    neg_next = neg_reg;
    ex_next = ex_reg;
    dvd_next = dvd_reg;
    rem_next = rem_reg;
    dsr_next = dsr_reg;
    root_next = root_reg;
    rad_next = rad_reg;
    shc_next = shc_reg;
    do_push = 1'b0;
    do_pop = 1'b0;
    s0_wr = 1'b0;
    s0_val = '0;
    fin = 1'b0;
    hold = 1'b0;
    rng = 1'b0;
    res = '0;
    e8 = acc_reg[30:23];
    isinv = e8 == `ASM_EMAX;
    // Denormal bit patterns are what integers look like
    nreal = (e8 == 8'h00) && (acc_reg[22:0] != '0);
    dn = (e8 > `ASM_ATAN_E) ? int'(e8) - `ASM_ATAN_E : 0;
    fx = f2fix(acc_reg, 0);
    fa = f2fix(acc_reg, dn);
    fxv = fx[33:0];
    absx = fxv[33] ? -fxv : fxv;
    sq = fxv * fxv;
    v = `ASM_ONE - sq[`ASM_FB+33:`ASM_FB];
    diff = acc_reg - stk_reg[0];
    kc = hwdata[`ASM_K_HI:`ASM_K_LO];
    xs = x_reg >>> cnt_reg;
    ys = y_reg >>> cnt_reg;
    at = atan_t(cnt_reg);
    dir = (st_reg == ST_ROT) ? !z_reg[33] : y_reg[33];
    sv = neg_reg ? -y_reg : y_reg;
    cv = neg_reg ? -x_reg : x_reg;
    abss = sv[33] ? -sv : sv;
    absc = cv[33] ? -cv : cv;
    zz = (op_reg == `ASM_OP_ACOS) ? `ASM_HPI - z_reg : z_reg;
    dr = {rem_reg, dvd_reg[63]};
    dge = dr >= {1'b0, dsr_reg};
    trial = root_reg | (32'h1 << cnt_reg);
    tsq = trial * trial;
    tok = tsq <= rad_reg;
    root_n = tok ? trial : root_reg;
    unique case (st_reg)
      ST_IDLE: begin
        if (wr_data) begin
          acc_next = hwdata;
          do_push = 1'b1;
        end
        if (wr_shc)
          shc_next = hwdata;
        if (wr_cmd) begin
          op_next = hwdata[`ASM_OP_HI:0];
          case (hwdata[`ASM_OP_HI:0])
            `ASM_OP_SUB: begin
              acc_next = diff;
              do_pop = 1'b1;
              flg_next[`ASM_F_ZERO] = zf(diff, 1'b0);
              flg_next[`ASM_F_NEG] = diff[31];
              flg_next[`ASM_F_SERR] = (acc_reg[31] != stk_reg[0][31]) &&
                                      (diff[31] != acc_reg[31]);
            end
            `ASM_OP_MUL: begin
              acc_next = acc_reg[15:0] * stk_reg[0][15:0];
              do_pop = 1'b1;
              flg_next[`ASM_F_ZERO] = zf(acc_next, 1'b0);
              flg_next[`ASM_F_NEG] = acc_next[31];
            end
            `ASM_OP_DIV: begin
              flg_next[`ASM_F_ZERO] = zf(acc_reg, 1'b0);
              flg_next[`ASM_F_NEG] = acc_reg[31];
              // Zero divisor is out of range; accumulator and stack keep their values
              flg_next[`ASM_F_RANGE] = stk_reg[0][15:0] == '0;
              if (stk_reg[0][15:0] != '0) begin
                dvd_next = {32'h0, acc_reg};
                dsr_next = {16'h0, stk_reg[0][15:0]};
                rem_next = '0;
                cnt_next = '0;
                st_next = ST_DIV;
              end
            end
            `ASM_OP_SIN, `ASM_OP_COS, `ASM_OP_TAN, `ASM_OP_ASIN,
            `ASM_OP_ACOS, `ASM_OP_ATAN, `ASM_OP_SQRT: begin
              // Invalid and non-real flags set here; sign error flag cleared
              flg_next[`ASM_F_INV] = isinv;
              flg_next[`ASM_F_NREAL] = nreal;
              flg_next[`ASM_F_SERR] = 1'b0;
              fin = isinv || nreal;
              hold = fin;
              cnt_next = '0;
              z_next = '0;
              if (!fin) begin
                case (hwdata[`ASM_OP_HI:0])
                  `ASM_OP_SIN, `ASM_OP_COS, `ASM_OP_TAN: begin
                    // Fold into +-pi/2; sin and cos both flip sign
                    if (fx[34] || absx > `ASM_PI) begin
                      rng = 1'b1;
                    end else begin
                      neg_next = absx > `ASM_HPI;
                      z_next = fxv;
                      if (fxv > $signed(`ASM_HPI))
                        z_next = fxv - `ASM_PI;
                      else if (fxv < -$signed(`ASM_HPI))
                        z_next = fxv + `ASM_PI;
                      x_next = `ASM_KGAIN;
                      y_next = '0;
                      st_next = ST_ROT;
                    end
                    fin = rng;
                  end
                  `ASM_OP_ATAN: begin
                    // Both legs scaled alike keeps any magnitude usable
                    x_next = `ASM_ONE >> dn;
                    y_next = fa[33:0];
                    st_next = ST_VEC;
                  end
                  `ASM_OP_ASIN, `ASM_OP_ACOS: begin
                    if (fx[34] || absx > `ASM_ONE) begin
                      rng = 1'b1;
                    end else begin
                      rad_next = {30'h0, v} << `ASM_FB;
                      root_next = '0;
                      y_next = fxv;
                      cnt_next = `ASM_SQTOP;
                      st_next = ST_SQRT;
                    end
                    fin = rng;
                  end
                  default: begin
                    rng = acc_reg[31] && acc_reg[30:0] != '0;
                    fin = rng || acc_reg[30:0] == '0;
                    if (!fin) begin
                      rad_next = e8[0] ? {40'h0, 1'b1, acc_reg[22:0]} << 23
                                       : {40'h0, 1'b1, acc_reg[22:0]} << 24;
                      ex_next = 8'((int'(e8) - `ASM_BIAS - int'(!e8[0])) / 2
                                   + `ASM_BIAS);
                      root_next = '0;
                      cnt_next = `ASM_SQTOP;
                      st_next = ST_SQRT;
                    end
                  end
                endcase
                hold = fin;
              end
            end
            `ASM_OP_SUM: begin
              acc_next = {26'h0, popcnt(acc_reg)};
              flg_next[`ASM_F_ZERO] = zf(acc_next, 1'b0);
            end
            `ASM_OP_SHLK, `ASM_OP_SHLM: begin
              // Counts of 32 or more leave zero; shifted-out bits are lost
              acc_next = (hwdata[`ASM_OP_HI:0] == `ASM_OP_SHLK)
                       ? acc_reg << kc : acc_reg << shc_reg;
              flg_next[`ASM_F_ZERO] = zf(acc_next, 1'b0);
              flg_next[`ASM_F_NEG] = acc_next[31];
            end
            default: begin
            end
          endcase
        end
      end
      ST_ROT, ST_VEC: begin
        if (cnt_reg != `ASM_NIT) begin
          if (dir) begin
            x_next = x_reg - ys;
            y_next = y_reg + xs;
            z_next = z_reg - at;
          end else begin
            x_next = x_reg + ys;
            y_next = y_reg - xs;
            z_next = z_reg + at;
          end
          cnt_next = cnt_reg + 7'h1;
        end else if (st_reg == ST_VEC) begin
          res = fix2f(zz);
          fin = 1'b1;
        end else if (op_reg == `ASM_OP_TAN) begin
          if (cv == '0) begin
            rng = 1'b1;
            fin = 1'b1;
          end else begin
            dvd_next = {30'h0, abss} << `ASM_FB;
            dsr_next = absc[31:0];
            rem_next = '0;
            neg_next = sv[33] ^ cv[33];
            cnt_next = '0;
            st_next = ST_DIV;
          end
        end else begin
          res = fix2f((op_reg == `ASM_OP_SIN) ? sv : cv);
          fin = 1'b1;
        end
      end
      ST_DIV: begin
        if (cnt_reg != `ASM_NDIV) begin
          dvd_next = {dvd_reg[62:0], dge};
          rem_next = dge ? 32'(dr - {1'b0, dsr_reg}) : dr[31:0];
          cnt_next = cnt_reg + 7'h1;
        end else if (op_reg == `ASM_OP_DIV) begin
          acc_next = dvd_reg[31:0];
          s0_wr = 1'b1;
          s0_val = rem_reg;
          flg_next[`ASM_F_ZERO] = zf(acc_next, 1'b0);
          flg_next[`ASM_F_NEG] = acc_next[31];
          st_next = ST_IDLE;
        end else begin
          // Quotient past the signed range means tangent overflow
          rng = dvd_reg[63:31] != '0;
          res = fix2f(neg_reg ? -{2'b0, dvd_reg[31:0]}
                              : {2'b0, dvd_reg[31:0]});
          fin = 1'b1;
        end
      end
      ST_SQRT: begin
        root_next = root_n;
        cnt_next = cnt_reg - 7'h1;
        if (cnt_reg == '0) begin
          if (op_reg == `ASM_OP_SQRT) begin
            res = {1'b0, ex_reg, root_n[22:0]};
            fin = 1'b1;
          end else begin
            x_next = {2'b0, root_n};
            z_next = '0;
            cnt_next = '0;
            st_next = ST_VEC;
          end
        end
      end
    endcase
    if (fin) begin
      if (!hold && !rng)
        acc_next = res;
      flg_next[`ASM_F_RANGE] = rng;
      flg_next[`ASM_F_ZERO] = zf(acc_next, 1'b1);
      flg_next[`ASM_F_NEG] = acc_next[31];
      st_next = ST_IDLE;
    end
    if (do_push) begin
      for (int i = STACK_DEPTH - 1; i > 0; i--)
        stk_next[i] = stk_reg[i - 1];
      stk_next[0] = acc_reg;
    end
    if (do_pop) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++)
        stk_next[i] = stk_reg[i + 1];
      stk_next[STACK_DEPTH - 1] = '0;
    end
    if (s0_wr)
      stk_next[0] = s0_val;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= ST_IDLE;
      acc_reg <= '0;
      stk_reg <= '{default: '0};
      flg_reg <= '0;
      op_reg <= '0;
      cnt_reg <= '0;
      x_reg <= '0;
      y_reg <= '0;
      z_reg <= '0;
      neg_reg <= 1'b0;
      ex_reg <= '0;
      dvd_reg <= '0;
      rem_reg <= '0;
      dsr_reg <= '0;
      root_reg <= '0;
      rad_reg <= '0;
      shc_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      acc_reg <= acc_next;
      stk_reg <= stk_next;
      flg_reg <= flg_next;
      op_reg <= op_next;
      cnt_reg <= cnt_next;
      x_reg <= x_next;
      y_reg <= y_next;
      z_reg <= z_next;
      neg_reg <= neg_next;
      ex_reg <= ex_next;
      dvd_reg <= dvd_next;
      rem_reg <= rem_next;
      dsr_reg <= dsr_next;
      root_reg <= root_next;
      rad_reg <= rad_next;
      shc_reg <= shc_next;
      busy_reg <= st_next != ST_IDLE;
    end
  end
endmodule

// [testbench/asm_math_unit_chk.sv]
`timescale 1ns/100ps
module asm_math_unit_chk #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic busy
);
  logic take;
  logic rd_reg;
  logic rd_next;
  logic wr_reg;
  logic wr_next;
  assign take = hsel & htrans[1] & hready;
  always_comb begin
    rd_next = rd_reg;
    wr_next = wr_reg;
    if (hreadyout) begin
      rd_next = 1'b0;
      wr_next = 1'b0;
    end
    if (take) begin
      rd_next = !hwrite;
      // Only DATA and CMD writes wait for a running operation
      wr_next = hwrite && (haddr[7:0] <= 8'h04);
    end
  end
  always_ff @(posedge clk) begin
    rd_reg <= srst ? 1'b0 : rd_next;
    wr_reg <= srst ? 1'b0 : wr_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_reset_idle: assert property (disable iff (1'b0)
    srst |=> hreadyout && !busy && hrdata == 32'h0 && !hresp)
    else $error("outputs not idle after reset");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  chk_accept_wait: assert property (take |=> !hreadyout)
    else $error("accepted transfer without wait state");
  chk_read_latency: assert property (take && !hwrite |=> ##1 hreadyout)
    else $error("read answer late");
  chk_ready_bound: assert property (!hreadyout |-> ##[0:130] hreadyout)
    else $error("bus stalled too long");
  chk_busy_bound: assert property ($rose(busy) |-> ##[1:100] !busy)
    else $error("operation never finished");
  chk_busy_start: assert property (
    $rose(busy) |-> hreadyout && !$past(hreadyout))
    else $error("busy rose outside a command write");
  chk_rdata_hold: assert property (!rd_reg |=> $stable(hrdata))
    else $error("read data changed without a read");
  chk_stall_busy: assert property (
    wr_reg && busy && $past(busy) |-> !hreadyout)
    else $error("write finished while busy");
  cover property (take && !hwrite);
  cover property ($rose(busy));
  cover property (wr_reg && busy && !hreadyout);
endmodule
bind asm_math_unit asm_math_unit_chk #(.STACK_DEPTH(STACK_DEPTH)) i_chk (
  .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy));

// [testbench/asm_seq_model.sv]
`timescale 1ns/100ps
module asm_seq_model (
  input wire logic clk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // One word transfer; entered right after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= {24'hff, ~a};
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    // Data no longer held: show a changed pattern
    hwdata <= ~hwdata;
  endtask
endmodule

// [testbench/asm_math_unit_tb.sv]
`timescale 1ns/100ps
`include "asm_regs.svh"
module asm_math_unit_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel, hwrite, hready, hreadyout, hresp, busy;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [4:0] r_op [8] = '{`ASM_OP_SIN, `ASM_OP_COS, `ASM_OP_TAN,
    `ASM_OP_ASIN, `ASM_OP_ACOS, `ASM_OP_ATAN, `ASM_OP_SQRT, `ASM_OP_COS};
  logic [31:0] r_in [8] = '{32'h3fc90fdb, 32'h0, 32'h3f490fdb,
    32'h3f000000, 32'h3f000000, 32'h3f800000, 32'h40800000, 32'hbf490fdb};
  logic [31:0] r_exp [8] = '{32'h3f800000, 32'h3f800000, 32'h3f800000,
    32'h3f060a92, 32'h3f860a92, 32'h3f490fdb, 32'h40000000, 32'h3f3504f3};
  always #2 clk = ~clk;
  assign hready = hreadyout;
  asm_math_unit #(.STACK_DEPTH(4)) i_asm_math_unit (.clk(clk), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .busy(busy));
  asm_seq_model i_asm_seq_model (.clk(clk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata));
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    // Whole run needs about a thousand cycles
    if (cyc == 20000) begin
      err_total++;
      end_sim;
    end
  end
  task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Fixed point core truncates: allow up to 64 units in the last place
  task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if ((^got) === 1'bx || ((got - exp) > 64 && (exp - got) > 64)) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_asm_seq_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff);
    i_asm_seq_model.xfer(1'b0, a, 32'h0, q);
    chk_eq(q & m, e);
  endtask
  task automatic ld2(input logic [31:0] a, input logic [31:0] b);
    wr(`ASM_A_DATA, a);
    wr(`ASM_A_DATA, b);
  endtask
  task automatic go(input logic [4:0] o, input logic [5:0] k = 6'h0);
    int n;
    wr(`ASM_A_CMD, {18'h0, k, 3'h0, o});
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk_eq({31'h0, busy}, 32'h0);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
    $display("test reset done");
  endtask
  task automatic t_stack;
    for (int i = 1; i <= 6; i++) wr(`ASM_A_DATA, 32'(i));
    rd(`ASM_A_STK, 32'h5);
    for (int i = 0; i < 4; i++) begin
      go(`ASM_OP_SUB);
      rd(`ASM_A_STK, (i == 3) ? 32'h0 : 32'(4 - i));
    end
    rd(`ASM_A_DATA, 32'hfffffff8);
    $display("test stack done");
  endtask
  task automatic t_sub;
    ld2(32'h7, 32'h7);
    go(`ASM_OP_SUB);
    rd(`ASM_A_DATA, 32'h0);
    rd(`ASM_A_FLG, 32'h02, 32'h16);
    ld2(32'h1, 32'h80000000);
    go(`ASM_OP_SUB);
    rd(`ASM_A_DATA, 32'h7fffffff);
    rd(`ASM_A_FLG, 32'h10, 32'h16);
    $display("test subtract done");
  endtask
  task automatic t_mul;
    ld2(32'hffff, 32'hffff);
    go(`ASM_OP_MUL);
    rd(`ASM_A_DATA, 32'hfffe0001);
    rd(`ASM_A_FLG, 32'h04, 32'h06);
    ld2(32'h3, 32'h10002);
    go(`ASM_OP_MUL);
    rd(`ASM_A_DATA, 32'h6);
    rd(`ASM_A_STK, 32'hfffe0001);
    $display("test multiply done");
  endtask
  task automatic t_div;
    ld2(32'h7, 32'd100);
    go(`ASM_OP_DIV);
    rd(`ASM_A_DATA, 32'd14);
    rd(`ASM_A_STK, 32'h2);
    rd(`ASM_A_FLG, 32'h0, 32'h07);
    ld2(32'h0, 32'h9);
    go(`ASM_OP_DIV);
    rd(`ASM_A_DATA, 32'h9);
    rd(`ASM_A_FLG, 32'h01, 32'h01);
    ld2(32'h3, 32'd10);
    wr(`ASM_A_CMD, {27'h0, `ASM_OP_DIV});
    rd(`ASM_A_CMD, 32'h80000003);
    wr(`ASM_A_DATA, 32'h55);
    rd(`ASM_A_DATA, 32'h55);
    rd(`ASM_A_STK, 32'h3);
    go(`ASM_OP_SUB);
    rd(`ASM_A_DATA, 32'h52);
    rd(`ASM_A_STK, 32'h1);
    $display("test divide done");
  endtask
  task automatic t_bits;
    wr(`ASM_A_DATA, 32'hf0f0000f);
    go(`ASM_OP_SUM);
    rd(`ASM_A_DATA, 32'd12);
    wr(`ASM_A_DATA, 32'h0);
    go(`ASM_OP_SUM);
    rd(`ASM_A_FLG, 32'h02, 32'h02);
    $display("test bit count done");
  endtask
  task automatic t_shift;
    wr(`ASM_A_DATA, 32'h80000003);
    go(`ASM_OP_SHLK, 6'd1);
    rd(`ASM_A_DATA, 32'h6);
    wr(`ASM_A_DATA, 32'h1);
    go(`ASM_OP_SHLK, 6'd31);
    rd(`ASM_A_DATA, 32'h80000000);
    rd(`ASM_A_FLG, 32'h04, 32'h06);
    wr(`ASM_A_SHC, 32'd32);
    rd(`ASM_A_SHC, 32'd32);
    wr(`ASM_A_DATA, 32'hffffffff);
    go(`ASM_OP_SHLM);
    rd(`ASM_A_DATA, 32'h0);
    rd(`ASM_A_FLG, 32'h02, 32'h06);
    wr(`ASM_A_SHC, 32'd4);
    wr(`ASM_A_DATA, 32'h12345678);
    go(`ASM_OP_SHLM);
    rd(`ASM_A_DATA, 32'h23456780);
    $display("test shift done");
  endtask
  task automatic t_real;
    for (int i = 0; i < 8; i++) begin
      wr(`ASM_A_DATA, r_in[i]);
      go(r_op[i]);
      i_asm_seq_model.xfer(1'b0, `ASM_A_DATA, 32'h0, q);
      chk_near(q, r_exp[i]);
      rd(`ASM_A_FLG, 32'h0, 32'h39);
    end
    wr(`ASM_A_DATA, 32'h7f800000);
    go(`ASM_OP_SIN);
    rd(`ASM_A_FLG, 32'h08, 32'h39);
    wr(`ASM_A_DATA, 32'h00000001);
    go(`ASM_OP_COS);
    rd(`ASM_A_FLG, 32'h20, 32'h39);
    wr(`ASM_A_DATA, 32'h40000000);
    go(`ASM_OP_ASIN);
    rd(`ASM_A_DATA, 32'h40000000);
    rd(`ASM_A_FLG, 32'h01, 32'h39);
    $display("test real done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_stack;
    t_sub;
    t_mul;
    t_div;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_bits;
    t_shift;
    t_real;
    end_sim;
  end
endmodule
